// >>> efs_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the halt block
// Assumes: 7-bit register addresses, 32-bit register data
// Notes: Definitions only
`ifndef EFS_CFG_SVH
`define EFS_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EFS_ADDR_HALT_CFG 7'h4E
`define EFS_ADDR_EVENT_REGISTER 7'h0E
`define EFS_ADDR_VEL 7'h22

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EFS_DECEL_MSB 23
`define EFS_DECEL_LSB 0
`define EFS_SCALE_MSB 31
`define EFS_SCALE_LSB 24
`define EFS_EVT_HALT_BIT 10

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define EFS_CFG_RST 32'h0000_0000
`define EFS_FILT_LEN 3
`define EFS_FRAC_BITS 37

`endif

// >>> efs_pkg.sv
// Purpose: Types shared by the halt block
// Assumes: Constants come from efs_cfg.svh
// Notes: Config struct matches the halt register bit layout
package efs_pkg;

  // ----------------------------------------
  // Stop sequence states
  // ----------------------------------------
  typedef enum logic [2:0] {
    EFS_RUN = 3'b001,
    EFS_STOP = 3'b010,
    EFS_STILL = 3'b100
  } efs_state_t;

  // ----------------------------------------
  // Register port request
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [31:0] wdata;
  } efs_reg_req_t;

  // Scale in 31:24, deceleration in 23:0
  typedef struct packed {
    logic [7:0] scale;
    logic [23:0] decel;
  } efs_cfg_t;

endpackage

// >>> efs_freeze.sv
// Purpose: Emergency halt of the velocity ramp with forced current scale
// Assumes: Halt pin is asynchronous; ramp and scaling logic share i_clk
// Notes: Register port is the decoded form of the host serial interface
//
// How it works
// RULE_01: Falling filtered halt input stops the running ramp at once, as configured.
// RULE_02: Halt sets event bit 10; it stays set until reset.
// RULE_03: Halt input is seen only after three consecutive low samples.
// RULE_04: Deceleration value lives in bits 23:0 of register 0x4E.
// RULE_05: Halt current scale lives in bits 31:24 of that register.
// RULE_06: One write after reset, only before any ramp start; then locked.
// RULE_07: Halt input is always active low; no polarity option.
// RULE_08: Halt register is readable at any time.
// RULE_09: Ramp velocity register stays readable while halted.
// RULE_10: Zero deceleration stops hard; nonzero ramps down linearly.
// RULE_11: Deceleration is a raw per-clock decrement scaled by two to 37.
// RULE_12: Zero halt scale keeps the last scale; otherwise use configured scale.
// RULE_13: Halt scale takes effect only once the halt event is raised.
// RULE_14: Halt scale drives current through the normal scaling path.
// RULE_15: Once halted, stay at standstill and ignore ramp starts until reset.
`include "efs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module efs_freeze
  import efs_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire efs_reg_req_t i_reg,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Halt pin
  input wire logic i_halt_input_n,
  // Ramp generator side
  input wire logic i_ramp_start,
  input wire logic signed [31:0] i_ramp_vel,
  output logic o_ramp_hold,
  output logic o_vel_force,
  output logic signed [31:0] o_vel,
  // Current scaling side
  input wire logic [7:0] i_scale_val,
  output logic o_scale_force,
  output logic [7:0] o_scale_val,
  // Status
  output logic o_halt_event_flag
);

  localparam int MAG_W = 32 + `EFS_FRAC_BITS;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic efs_hit(input efs_reg_req_t req,
                                   input logic [6:0] target);
    efs_hit = (req.addr == target);
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic meta_q;
  logic sync_q;
  logic [`EFS_FILT_LEN-1:0] filt_sh_q;
  logic filt_q;
  logic halt_fall;
  logic flag_q;
  efs_state_t state_q;
  efs_state_t state_d;
  efs_cfg_t cfg_q;
  logic cfg_lock_q;
  logic cfg_wr;
  logic [MAG_W-1:0] mag_q;
  logic [MAG_W-1:0] mag_d;
  logic [MAG_W-1:0] step;
  logic [31:0] abs_in;
  logic [31:0] mag_int;
  logic neg_q;
  logic neg_d;
  logic signed [31:0] vel_q;
  logic [7:0] scale_q;
  logic [31:0] rdata_q;
  logic rvalid_q;

  // ----------------------------------------
  // Halt pin synchroniser and filter
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= i_halt_input_n;
      sync_q <= meta_q;
    end
  end

  // Glitches shorter than the window never reach the ramp
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      filt_sh_q <= '1;
    end else begin
      filt_sh_q <= {filt_sh_q[`EFS_FILT_LEN-2:0], sync_q}; // [RULE_03]
    end
  end

  // Fixed low-active sense, no invert option
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      filt_q <= 1'b1;
    end else if (filt_sh_q == '0) begin
      filt_q <= 1'b0; // [RULE_03] [RULE_07]
    end else if (filt_sh_q == '1) begin
      filt_q <= 1'b1;
    end
  end

  // First fall only: a later pulse must not re-pick the held scale
  assign halt_fall = filt_q && (filt_sh_q == '0) && !flag_q; // [RULE_01] [RULE_07] [RULE_12]

  // ----------------------------------------
  // Halt event flag
  // ----------------------------------------
  // Only reset clears it, so no set/clear race exists
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flag_q <= 1'b0;
    end else if (halt_fall) begin
      flag_q <= 1'b1; // [RULE_02]
    end
  end

  // ----------------------------------------
  // Halt configuration register
  // ----------------------------------------
  assign cfg_wr = i_reg.wr && efs_hit(i_reg, `EFS_ADDR_HALT_CFG) && !cfg_lock_q;

  // Locked so corrupted host traffic cannot disarm the stop
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_q <= `EFS_CFG_RST;
    end else if (cfg_wr) begin
      cfg_q <= i_reg.wdata; // [RULE_04] [RULE_05] [RULE_06]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_lock_q <= 1'b0;
    end else if (cfg_wr || i_ramp_start) begin
      cfg_lock_q <= 1'b1; // [RULE_06]
    end
  end

  // ----------------------------------------
  // Stop sequence
  // ----------------------------------------
  assign step = {{(MAG_W-24){1'b0}}, cfg_q.decel}; // [RULE_11]
  assign abs_in = i_ramp_vel[31] ? (~i_ramp_vel + 32'h1) : i_ramp_vel;

  always_comb begin
    state_d = state_q;
    mag_d = mag_q;
    neg_d = neg_q;
    unique case (state_q)
      EFS_RUN: begin
        if (halt_fall) begin
          neg_d = i_ramp_vel[31];
          if (cfg_q.decel == 24'h0) begin
            mag_d = '0; // [RULE_10]
            state_d = EFS_STILL;
          end else begin
            mag_d = {abs_in, {`EFS_FRAC_BITS{1'b0}}}; // [RULE_01]
            state_d = EFS_STOP;
          end
        end
      end
      EFS_STOP: begin
        if (mag_q <= step) begin
          mag_d = '0;
          state_d = EFS_STILL;
        end else begin
          mag_d = mag_q - step; // [RULE_10] [RULE_11]
        end
      end
      EFS_STILL: begin
        mag_d = '0; // [RULE_15]
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= EFS_RUN;
      mag_q <= '0;
      neg_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mag_q <= mag_d;
      neg_q <= neg_d;
    end
  end

  assign mag_int = mag_d[MAG_W-1:`EFS_FRAC_BITS];

  // Integer velocity forced onto the ramp while halted
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      vel_q <= 32'sh0;
    end else begin
      vel_q <= neg_d ? $signed(~mag_int + 32'h1) : $signed(mag_int);
    end
  end

  // ----------------------------------------
  // Halt current scale
  // ----------------------------------------
  // Chosen once at the halt edge, then held until reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      scale_q <= 8'h0;
    end else if (halt_fall) begin
      if (cfg_q.scale != 8'h0) begin
        scale_q <= cfg_q.scale; // [RULE_12] [RULE_13]
      end else begin
        scale_q <= i_scale_val; // [RULE_12]
      end
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= i_reg.rd;
      rdata_q <= 32'h0;
      if (i_reg.rd) begin
        if (efs_hit(i_reg, `EFS_ADDR_HALT_CFG)) begin
          rdata_q <= cfg_q; // [RULE_08]
        end else if (efs_hit(i_reg, `EFS_ADDR_EVENT_REGISTER)) begin
          rdata_q[`EFS_EVT_HALT_BIT] <= flag_q; // [RULE_02]
        end else if (efs_hit(i_reg, `EFS_ADDR_VEL)) begin
          rdata_q <= vel_q; // [RULE_09]
        end
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;
  assign o_ramp_hold = flag_q; // [RULE_15]
  assign o_vel_force = !state_q[0]; // [RULE_01]
  assign o_vel = vel_q;
  assign o_scale_force = flag_q; // [RULE_13] [RULE_14]
  assign o_scale_val = scale_q; // [RULE_14]
  assign o_halt_event_flag = flag_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_halt_flag_set: assert property ( // [RULE_02]
    halt_fall |=> o_halt_event_flag
  ) else $error("halt flag not set after halt edge");

  a_flag_sticky: assert property ( // [RULE_02]
    o_halt_event_flag |=> o_halt_event_flag [*8]
  ) else $error("halt flag dropped before reset");

  a_filter_three: assert property ( // [RULE_03]
    $fell(filt_q) |-> $past(sync_q, 2) == 1'b0 && $past(sync_q, 3) == 1'b0
      && $past(sync_q, 4) == 1'b0
  ) else $error("halt recognised without three low samples");

  a_cfg_locked: assert property ( // [RULE_06]
    cfg_lock_q |=> $stable(cfg_q) && cfg_lock_q
  ) else $error("halt config changed after lock");

  a_cfg_write: assert property ( // [RULE_04]
    cfg_wr |=> cfg_q == $past(i_reg.wdata) && cfg_lock_q
  ) else $error("halt config write not taken");

  a_cfg_read: assert property ( // [RULE_08]
    i_reg.rd && efs_hit(i_reg, `EFS_ADDR_HALT_CFG)
      |=> o_reg_rvalid && o_reg_rdata == $past(cfg_q)
  ) else $error("halt config read wrong");

  a_hard_stop: assert property ( // [RULE_10]
    halt_fall && cfg_q.decel == 24'h0 |=> o_vel == 32'sh0 && state_q == EFS_STILL
  ) else $error("hard stop did not zero velocity");

  a_linear_step: assert property ( // [RULE_11]
    state_q == EFS_STOP && mag_q > step |=> mag_q == $past(mag_q) - $past(step)
  ) else $error("deceleration step wrong");

  a_scale_pick: assert property ( // [RULE_12]
    halt_fall |=> o_scale_force && o_scale_val == ($past(cfg_q.scale) != 8'h0 ?
      $past(cfg_q.scale) : $past(i_scale_val))
  ) else $error("halt scale value wrong");

  a_scale_gate: assert property ( // [RULE_13]
    !o_halt_event_flag |-> !o_scale_force && o_scale_val == 8'h00
  ) else $error("halt scale applied before event");

  a_still_zero: assert property ( // [RULE_15]
    state_q == EFS_STILL |-> o_vel == 32'sh0 && o_vel_force && o_ramp_hold
  ) else $error("motor not held at standstill");

endmodule

`default_nettype wire

// >>> efs_halt_src.sv
// Purpose: Board safety logic model driving the halt pin
// Assumes: Pulses counted in i_clk cycles
// Notes: i_len of FF holds the pin low until reset
`timescale 1ns/1ps
`default_nettype none
module efs_halt_src (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Command
  input wire logic i_go,
  input wire logic [7:0] i_len,
  // Halt pin
  output logic o_halt_input_n
);
  logic [7:0] cnt_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= 8'h00;
    end else if (i_go) begin
      cnt_q <= i_len;
    end else if (cnt_q != 8'h00 && cnt_q != 8'hFF) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  // Driven high when idle, low for i_len cycles
  assign o_halt_input_n = (cnt_q == 8'h00);
endmodule
`default_nettype wire

// >>> emergency_freeze_stop_tb_top.sv
// Purpose: Self-checking bench for the halt block
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Flag is sticky, so each scenario starts with a reset
`timescale 1ns/1ps
`default_nettype none
module emergency_freeze_stop_tb_top;
  import efs_pkg::*;
  logic clk, rst_n, rvalid, start, go, halt_n, hold, vforce, sforce, flag;
  logic [31:0] rdata;
  logic signed [31:0] vel_in, vel;
  logic [7:0] sc_in, sc, len;
  efs_reg_req_t req;
  int error_cnt = 0;
  int check_count = 0;
  efs_freeze u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_reg(req), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_halt_input_n(halt_n), .i_ramp_start(start),
    .i_ramp_vel(vel_in), .o_ramp_hold(hold), .o_vel_force(vforce), .o_vel(vel),
    .i_scale_val(sc_in), .o_scale_force(sforce), .o_scale_val(sc), .o_halt_event_flag(flag));
  efs_halt_src u_src (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_len(len),
    .o_halt_input_n(halt_n));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    req = {2'b10, a, d};
    tick(1);
    req = '0;
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
    req = {2'b01, a, 32'h0000_0000};
    tick(1);
    req = '0;
    chk({31'h0, rvalid}, 32'h0000_0001);
    chk(rdata, exp);
  endtask
  task automatic halt(input logic [7:0] n);
    go = 1'b1;
    len = n;
    tick(1);
    go = 1'b0;
  endtask
  task automatic wait_flag;
    for (int i = 0; i < 20 && flag !== 1'b1; i++) tick(1);
    if (flag !== 1'b1) begin
      error_cnt++;
      $display("unexpected t=%0t got=%h exp=%h", $time, flag, 1'b1);
      end_of_test;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    do_reset;
    rd_chk(7'h4E, 32'h0000_0000);
    rd_chk(7'h0E, 32'h0000_0000);
    wr(7'h4E, 32'h5A80_0000);
    wr(7'h4E, 32'h1111_1111);
    rd_chk(7'h4E, 32'h5A80_0000);
    rd_chk(7'h10, 32'h0000_0000);
  endtask
  task automatic t_lock;
    do_reset;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    wr(7'h4E, 32'h1234_5678);
    rd_chk(7'h4E, 32'h0000_0000);
  endtask
  task automatic t_hard;
    do_reset;
    vel_in = 32'sd300;
    sc_in = 8'h33;
    halt(8'h02);
    tick(8);
    chk({31'h0, flag}, 32'h0);
    chk({31'h0, sforce}, 32'h0);
    halt(8'h03);
    wait_flag;
    chk({31'h0, vforce}, 32'h1);
    chk(vel, 32'h0);
    chk({31'h0, sforce}, 32'h1);
    chk({24'h0, sc}, 32'h33);
    chk({31'h0, hold}, 32'h1);
    sc_in = 8'h44;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(3);
    chk({24'h0, sc}, 32'h33);
    chk(vel, 32'h0);
    rd_chk(7'h0E, 32'h0000_0400);
    rd_chk(7'h22, 32'h0000_0000);
    chk({31'h0, flag}, 32'h1);
  endtask
  // Velocity 2 with step 2^23: integer part stays 1 for 2^14 steps
  task automatic t_linear;
    do_reset;
    wr(7'h4E, 32'h5A80_0000);
    vel_in = 32'sd2;
    halt(8'h03);
    wait_flag;
    chk(vel, 32'h2);
    chk({24'h0, sc}, 32'h5A);
    tick(1);
    chk(vel, 32'h1);
    tick(16380);
    chk(vel, 32'h1);
    rd_chk(7'h22, 32'h0000_0001);
    tick(10);
    chk(vel, 32'h0);
  endtask
  // Negative velocity, zero halt scale, then a second halt pulse
  task automatic t_neg;
    do_reset;
    sc_in = 8'h21;
    vel_in = -32'sd2;
    wr(7'h4E, 32'h0000_0001);
    halt(8'h03);
    wait_flag;
    chk(vel, 32'hFFFF_FFFE);
    chk({24'h0, sc}, 32'h21);
    tick(1);
    chk(vel, 32'hFFFF_FFFF);
    sc_in = 8'h55;
    halt(8'h03);
    tick(10);
    chk({24'h0, sc}, 32'h21);
    chk({31'h0, flag}, 32'h1);
  endtask
  initial begin
    rst_n = 1'b0;
    req = '0;
    start = 1'b0;
    go = 1'b0;
    len = 8'h00;
    vel_in = 32'sd0;
    sc_in = 8'h00;
    tick(1);
    t_regs;
    t_lock;
    t_hard;
    t_linear;
    t_neg;
    end_of_test;
  end
endmodule
`default_nettype wire
